// *** logic/led_link_pkg.sv ***
// Shared constants and types for the control-pin link of the LED boost driver
package led_link_pkg;

  // Clock and counter widths
  localparam int CW = 17;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int CONV_HZ = 600_000;
  localparam logic [5:0] CONV_DIV = 6'(CLK_HZ / CONV_HZ);

  // Times in nanoseconds
  localparam int STEP_NS = 213_000;
  localparam int HALF_NS = 5_000_000;
  localparam int SHUT_NS = 2_500_000;
  localparam int WIN_NS = 1_000_000;
  localparam int SELDLY_NS = 100_000;
  localparam int SELLOW_NS = 260_000;
  localparam int ACK_NS = 512_000;
  localparam int EOS_NS = 360_000;
  localparam int UNIT_NS = 10_000;

  // Cycle counts: least times round up, longest times round down
  localparam logic [CW-1:0] STEP_CYC = CW'((STEP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] HALF_CYC = CW'((HALF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] SHUT_CYC = CW'((SHUT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] WIN_CYC = CW'((WIN_NS * CLK_MHZ) / 1000);
  localparam logic [CW-1:0] SELDLY_CYC = CW'((SELDLY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] SELLOW_CYC = CW'((SELLOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] ACK_CYC = CW'((ACK_NS * CLK_MHZ) / 1000);
  localparam logic [CW-1:0] EOS_CYC = CW'((EOS_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] UNIT_CYC = CW'((UNIT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CW-1:0] LONG_CYC = CW'(3 * ((UNIT_NS * CLK_MHZ + 999) / 1000));
  localparam logic [CW-1:0] MARGIN_CYC = 17'h00008;

  // Protocol and analog-target values
  localparam logic [5:0] RAMP_STEPS = 6'h20;
  localparam logic [3:0] OVP_CNT = 4'h8;
  localparam logic [7:0] DEV_ADDR = 8'h72;
  localparam logic [4:0] FULL_CODE = 5'h1f;
  localparam logic [7:0] REF_MV = 8'hc8;
  localparam int FILT_SHIFT = 7;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  localparam int ACK_BIT = 7;
  localparam int SUB_HI = 6;
  localparam int SUB_LO = 5;

  // Host command opcodes
  localparam logic [1:0] OP_PWM = 2'h0;
  localparam logic [1:0] OP_ONEWIRE = 2'h1;
  localparam logic [1:0] OP_SEND = 2'h2;
  localparam logic [1:0] OP_OFF = 2'h3;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_FAULT = 3'b100
  } dev_state_t;

  typedef enum logic [8:0] {
    H_IDLE = 9'b000000001,
    H_ENW = 9'b000000010,
    H_SEL = 9'b000000100,
    H_GUARD = 9'b000001000,
    H_START = 9'b000010000,
    H_BHI = 9'b000100000,
    H_BLO = 9'b001000000,
    H_ACKW = 9'b010000000,
    H_SHUT = 9'b100000000
  } host_state_t;

endpackage

// *** logic/led_link_if.sv ***
// Control-pin wire shared by the host and the device, with pull-up
`timescale 1ns/1ps
interface led_link_if;
  logic host_o;
  logic host_oe_n;
  logic dev_o;
  logic dev_oe_n;
  logic line;

  // Released drivers leave the line pulled high
  assign line = (host_oe_n ? 1'b1 : host_o) & (dev_oe_n ? 1'b1 : dev_o);

  modport device (input line, output dev_o, output dev_oe_n);
  modport host (input line, output host_o, output host_oe_n);
endinterface

// *** logic/led_dev_end.sv ***
// Device end: control-pin logic of the LED boost driver
`timescale 1ns/1ps
module led_dev_end
  import led_link_pkg::*;
#(
  parameter logic [CW-1:0] HALF_P = HALF_CYC,
  parameter logic [CW-1:0] SHUT_P = SHUT_CYC,
  parameter logic [CW-1:0] WIN_P = WIN_CYC,
  parameter logic [CW-1:0] SELLOW_P = SELLOW_CYC,
  parameter logic [CW-1:0] ACK_P = ACK_CYC,
  parameter logic [CW-1:0] EOS_P = EOS_CYC
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  led_link_if.device LINK,
  input wire logic SW_OVER,
  input wire logic FB_LOW,
  output logic SWITCH_EN,
  output logic HALF_LIMIT,
  output logic FAULT,
  output logic ONEWIRE_MODE,
  output logic [4:0] BRIGHTNESS,
  output logic [7:0] FB_TARGET
);

  // Brightness code to feedback target in mV
  function automatic logic [7:0] code_mv(input logic [4:0] c);
    logic [7:0] k;
    k = {3'h0, c};
    if (c == 5'h00) begin
      code_mv = 8'h00;
    end else if (c <= 5'h0c) begin
      code_mv = 8'h02 + k * 8'h03;
    end else if (c <= 5'h17) begin
      code_mv = 8'h26 + (k - 8'h0c) * 8'h06;
    end else begin
      code_mv = 8'h68 + (k - 8'h17) * 8'h0c;
    end
  endfunction

  dev_state_t state_ff, nxt_state;
  logic [5:0] div_ff, nxt_div;
  logic prev_ff, nxt_prev;
  logic [CW-1:0] lowc_ff, nxt_lowc, hic_ff, nxt_hic, hl_ff, nxt_hl;
  logic [CW-1:0] up_ff, nxt_up, stepc_ff, nxt_stepc, ackc_ff, nxt_ackc;
  logic [5:0] step_ff, nxt_step;
  logic mode_ff, nxt_mode, locked_ff, nxt_locked, selok_ff, nxt_selok;
  logic [3:0] ovp_ff, nxt_ovp;
  logic [15:0] filt_ff, nxt_filt, sh_ff, nxt_sh;
  logic started_ff, nxt_started, half_ff, nxt_half;
  logic [4:0] bits_ff, nxt_bits, bright_ff, nxt_bright;
  logic [7:0] fb_ff, nxt_fb;
  logic line, rise, fall, tick;

  assign line = LINK.line;
  assign rise = line & ~prev_ff;
  assign fall = ~line & prev_ff;
  assign tick = (div_ff == CONV_DIV - 6'h01);

  // Open-drain acknowledge: only ever pulls low
  assign LINK.dev_o = 1'b0;
  assign LINK.dev_oe_n = (ackc_ff == '0);
  assign SWITCH_EN = (state_ff == ST_RUN);
  assign FAULT = (state_ff == ST_FAULT);
  assign HALF_LIMIT = half_ff;
  assign ONEWIRE_MODE = mode_ff;
  assign BRIGHTNESS = bright_ff;
  assign FB_TARGET = fb_ff;

  // Converter clock divider
  always_comb begin
    nxt_div = tick ? 6'h00 : div_ff + 6'h01;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_ff <= 6'h00;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // Enable, mode selection, ramp, protection and serial receive
  always_comb begin
    logic [15:0] word;
    logic [16:0] diff;
    logic [7:0] ref_mv;
    logic [13:0] prod;
    word = {sh_ff[14:0], (hl_ff > lowc_ff)};
    ref_mv = 8'h00;
    prod = 14'h0000;
    diff = 17'({1'b0, (line ? REF_MV : 8'h00), 8'h00}) - {1'b0, filt_ff};
    nxt_state = state_ff;
    nxt_prev = line;
    nxt_lowc = line ? '0 : ((lowc_ff == '1) ? lowc_ff : lowc_ff + 1'b1);
    nxt_hic = !line ? '0 : ((hic_ff == '1) ? hic_ff : hic_ff + 1'b1);
    nxt_hl = hl_ff;
    nxt_up = up_ff;
    nxt_stepc = stepc_ff;
    nxt_step = step_ff;
    nxt_mode = mode_ff;
    nxt_locked = locked_ff;
    nxt_selok = selok_ff;
    nxt_ovp = ovp_ff;
    nxt_filt = filt_ff;
    nxt_sh = sh_ff;
    nxt_started = started_ff;
    nxt_bits = bits_ff;
    nxt_bright = bright_ff;
    nxt_ackc = (ackc_ff != '0) ? ackc_ff - 1'b1 : ackc_ff;
    // chopped reference through a first-order low-pass
    if (tick) begin
      nxt_filt = filt_ff + 16'($signed(diff) >>> FILT_SHIFT);
    end
    case (state_ff)
      ST_OFF: begin
        if (rise) begin
          nxt_state = ST_RUN;
          nxt_up = '0;
          nxt_step = 6'h00;
          nxt_stepc = '0;
          nxt_ovp = 4'h0;
          nxt_mode = 1'b0;
          nxt_locked = 1'b0;
          nxt_selok = 1'b0;
          nxt_started = 1'b0;
          nxt_bits = 5'h00;
        end
      end
      ST_RUN: begin
        if (step_ff != RAMP_STEPS) begin
          if (stepc_ff == STEP_CYC - 1'b1) begin
            nxt_stepc = '0;
            nxt_step = step_ff + 6'h01;
          end else begin
            nxt_stepc = stepc_ff + 1'b1;
          end
        end
        if (up_ff != HALF_P) begin
          nxt_up = up_ff + 1'b1;
        end
        if (!locked_ff) begin
          if (fall) begin
            nxt_selok = (up_ff >= SELDLY_CYC) && (up_ff < WIN_P);
          end
          if (!line && selok_ff && lowc_ff > SELLOW_P && up_ff < WIN_P) begin
            nxt_mode = 1'b1;
            nxt_locked = 1'b1;
          end else if (up_ff >= WIN_P) begin
            nxt_locked = 1'b1;
          end
        end
        if (tick) begin
          if (SW_OVER && FB_LOW) begin
            nxt_ovp = ovp_ff + 4'h1;
            if (ovp_ff == OVP_CNT - 4'h1) begin
              nxt_state = ST_FAULT;
            end
          end else begin
            nxt_ovp = 4'h0;
          end
        end
        if (mode_ff && ackc_ff == '0) begin
          if (fall) begin
            nxt_hl = hic_ff;
            // long idle high: next low is a start
            if (hic_ff >= EOS_P) begin
              nxt_started = 1'b0;
              nxt_bits = 5'h00;
            end
          end
          // long low discards a partial transfer
          if (!line && lowc_ff >= EOS_P) begin
            nxt_started = 1'b0;
            nxt_bits = 5'h00;
          end
          if (rise) begin
            if (!started_ff) begin
              nxt_started = 1'b1;
              nxt_bits = 5'h00;
            end else begin
              nxt_sh = word;
              nxt_bits = bits_ff + 5'h01;
              if (bits_ff == LAST_BIT) begin
                nxt_started = 1'b0;
                nxt_bits = 5'h00;
                if (word[15:8] == DEV_ADDR && !word[SUB_HI] &&
                    !word[SUB_LO]) begin
                  nxt_bright = word[4:0];
                  if (word[ACK_BIT]) begin
                    nxt_ackc = ACK_P;
                  end
                end
              end
            end
          end
        end
      end
      ST_FAULT: begin
        if (rise) begin
          nxt_state = ST_RUN;
          nxt_up = '0;
          nxt_step = 6'h00;
          nxt_stepc = '0;
          nxt_ovp = 4'h0;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    if (state_ff != ST_OFF && lowc_ff > SHUT_P) begin
      nxt_state = ST_OFF;
      nxt_ackc = '0;
    end
    nxt_half = (nxt_state == ST_RUN) && (state_ff == ST_RUN) &&
               (up_ff < HALF_P);
    // code table in one-wire mode, filtered pin level otherwise; ramp scales the target
    ref_mv = mode_ff ? code_mv(bright_ff) : filt_ff[15:8];
    prod = {6'h00, ref_mv} * {8'h00, step_ff};
    nxt_fb = (state_ff == ST_RUN) ? prod[12:5] : 8'h00;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_OFF;
      prev_ff <= 1'b0;
      lowc_ff <= '0;
      hic_ff <= '0;
      hl_ff <= '0;
      up_ff <= '0;
      stepc_ff <= '0;
      step_ff <= 6'h00;
      mode_ff <= 1'b0;
      locked_ff <= 1'b0;
      selok_ff <= 1'b0;
      ovp_ff <= 4'h0;
      filt_ff <= 16'h0000;
      sh_ff <= 16'h0000;
      started_ff <= 1'b0;
      bits_ff <= 5'h00;
      bright_ff <= FULL_CODE;
      ackc_ff <= '0;
      half_ff <= 1'b0;
      fb_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      prev_ff <= nxt_prev;
      lowc_ff <= nxt_lowc;
      hic_ff <= nxt_hic;
      hl_ff <= nxt_hl;
      up_ff <= nxt_up;
      stepc_ff <= nxt_stepc;
      step_ff <= nxt_step;
      mode_ff <= nxt_mode;
      locked_ff <= nxt_locked;
      selok_ff <= nxt_selok;
      ovp_ff <= nxt_ovp;
      filt_ff <= nxt_filt;
      sh_ff <= nxt_sh;
      started_ff <= nxt_started;
      bits_ff <= nxt_bits;
      bright_ff <= nxt_bright;
      ackc_ff <= nxt_ackc;
      half_ff <= nxt_half;
      fb_ff <= nxt_fb;
    end
  end

endmodule

// *** logic/led_host_end.sv ***
// Host end: command FIFO and control-pin driver
`timescale 1ns/1ps
module cmd_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ff, nxt_wr, rd_ff, nxt_rd;

  // Pointer flags
  assign in_ready = !((wr_ff[AW] != rd_ff[AW]) &&
                      (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
  assign out_valid = (wr_ff != rd_ff);
  assign out_data = mem[rd_ff[AW-1:0]];

  // Pointer advance on each accepted word
  always_comb begin
    nxt_wr = wr_ff + ((in_valid && in_ready) ? 1'b1 : 1'b0);
    nxt_rd = rd_ff + ((out_valid && out_ready) ? 1'b1 : 1'b0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

module led_host_end
  import led_link_pkg::*;
#(
  parameter logic [CW-1:0] SHUT_P = SHUT_CYC,
  parameter logic [CW-1:0] SELLOW_P = SELLOW_CYC,
  parameter logic [CW-1:0] ACK_P = ACK_CYC,
  parameter logic [CW-1:0] EOS_P = EOS_CYC
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  led_link_if.host LINK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [1:0] CMD_OP,
  input wire logic [7:0] CMD_DATA,
  output logic BUSY,
  output logic ACK_OK,
  output logic ACK_MISS
);
  host_state_t st_ff, nxt_st;
  logic [CW-1:0] tmr_ff, nxt_tmr;
  logic drv_ff, nxt_drv, rel_ff, nxt_rel, pend_ff, nxt_pend;
  logic rfa_ff, nxt_rfa, seen_ff, nxt_seen;
  logic ok_ff, nxt_ok, miss_ff, nxt_miss;
  logic [15:0] sh_ff, nxt_sh;
  logic [4:0] nb_ff, nxt_nb;
  logic f_valid, f_ready;
  logic [9:0] f_data;
  logic done;

  cmd_fifo #(.W(10), .D(16)) u_fifo (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .in_valid(CMD_VALID),
    .in_ready(CMD_READY),
    .in_data({CMD_OP, CMD_DATA}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  assign f_ready = (st_ff == H_IDLE);
  assign done = (tmr_ff == '0);
  assign LINK.host_o = drv_ff;
  assign LINK.host_oe_n = rel_ff;
  assign BUSY = (st_ff != H_IDLE) || f_valid;
  assign ACK_OK = ok_ff;
  assign ACK_MISS = miss_ff;

  // Pin sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = done ? tmr_ff : tmr_ff - 1'b1;
    nxt_drv = drv_ff;
    nxt_rel = rel_ff;
    nxt_pend = pend_ff;
    nxt_rfa = rfa_ff;
    nxt_seen = seen_ff;
    nxt_ok = 1'b0;
    nxt_miss = 1'b0;
    nxt_sh = sh_ff;
    nxt_nb = nb_ff;
    case (st_ff)
      H_IDLE: begin
        if (f_valid) begin
          nxt_drv = 1'b1;
          nxt_pend = 1'b0;
          nxt_st = H_GUARD;
          nxt_tmr = EOS_P + MARGIN_CYC;
          if (f_data[9:8] == OP_ONEWIRE) begin
            nxt_st = H_ENW;
            nxt_tmr = SELDLY_CYC + MARGIN_CYC;
          end else if (f_data[9:8] == OP_SEND) begin
            // data byte sent unchanged, MSB first
            nxt_sh = {DEV_ADDR, f_data[7:0]};
            nxt_rfa = f_data[ACK_BIT];
            nxt_pend = 1'b1;
          end else if (f_data[9:8] == OP_OFF) begin
            nxt_drv = 1'b0;
            nxt_st = H_SHUT;
            nxt_tmr = SHUT_P + MARGIN_CYC;
          end
        end
      end
      H_ENW: begin
        if (done) begin
          nxt_drv = 1'b0;
          nxt_st = H_SEL;
          nxt_tmr = SELLOW_P + MARGIN_CYC;
        end
      end
      H_SEL: begin
        if (done) begin
          nxt_drv = 1'b1;
          nxt_st = H_GUARD;
          nxt_tmr = EOS_P + MARGIN_CYC;
        end
      end
      H_GUARD: begin
        if (done) begin
          if (pend_ff) begin
            nxt_drv = 1'b0;
            nxt_st = H_START;
            nxt_tmr = UNIT_CYC - 1'b1;
          end else begin
            nxt_st = H_IDLE;
          end
        end
      end
      H_START: begin
        if (done) begin
          nxt_drv = 1'b1;
          nxt_nb = 5'h00;
          nxt_st = H_BHI;
          nxt_tmr = (sh_ff[15] ? LONG_CYC : UNIT_CYC) - 1'b1;
        end
      end
      H_BHI: begin
        // long high for one, short for zero
        if (done) begin
          nxt_drv = 1'b0;
          nxt_st = H_BLO;
          nxt_tmr = (sh_ff[15] ? UNIT_CYC : LONG_CYC) - 1'b1;
        end
      end
      H_BLO: begin
        if (done) begin
          nxt_sh = {sh_ff[14:0], 1'b0};
          if (nb_ff == LAST_BIT) begin
            nxt_rel = 1'b1;
            nxt_seen = 1'b0;
            nxt_st = H_ACKW;
            nxt_tmr = ACK_P + MARGIN_CYC;
          end else begin
            nxt_nb = nb_ff + 5'h01;
            nxt_drv = 1'b1;
            nxt_st = H_BHI;
            nxt_tmr = (sh_ff[14] ? LONG_CYC : UNIT_CYC) - 1'b1;
          end
        end
      end
      H_ACKW: begin
        // watch the released line for acknowledge
        if (!LINK.line) begin
          nxt_seen = 1'b1;
        end
        if (done) begin
          nxt_rel = 1'b0;
          nxt_drv = 1'b1;
          nxt_st = H_IDLE;
          nxt_ok = rfa_ff && seen_ff;
          nxt_miss = rfa_ff && !seen_ff;
        end
      end
      H_SHUT: begin
        if (done) begin
          nxt_st = H_IDLE;
        end
      end
      default: begin
        nxt_st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= H_IDLE;
      tmr_ff <= '0;
      drv_ff <= 1'b0;
      rel_ff <= 1'b0;
      pend_ff <= 1'b0;
      rfa_ff <= 1'b0;
      seen_ff <= 1'b0;
      ok_ff <= 1'b0;
      miss_ff <= 1'b0;
      sh_ff <= 16'h0000;
      nb_ff <= 5'h00;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      drv_ff <= nxt_drv;
      rel_ff <= nxt_rel;
      pend_ff <= nxt_pend;
      rfa_ff <= nxt_rfa;
      seen_ff <= nxt_seen;
      ok_ff <= nxt_ok;
      miss_ff <= nxt_miss;
      sh_ff <= nxt_sh;
      nb_ff <= nxt_nb;
    end
  end
endmodule

// *** dv/led_link_chk.sv ***
// Checker on the control-pin wire between host end and device end
`timescale 1ns/1ps
module led_link_chk
  import led_link_pkg::*;
#(
  parameter logic [CW-1:0] ACK_P = ACK_CYC
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic host_o,
  input wire logic host_oe_n,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  input wire logic line
);
  logic [CW-1:0] low_cnt_ff;
  logic [CW-1:0] nxt_low_cnt;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // Length of the current acknowledge pull
  always_comb begin
    nxt_low_cnt = dev_oe_n ? '0 : low_cnt_ff + 1'b1;
  end
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  // Early part of an acknowledge pull
  sequence ack_pull;
    !dev_oe_n [*8];
  endsequence
  sequence ack_begin;
    $fell(dev_oe_n);
  endsequence

  AST_ACK_LEN: assert property ($rose(dev_oe_n) |-> low_cnt_ff == ACK_P)
    else $error("acknowledge pull length wrong");
  AST_ACK_SRC: assert property (ack_begin |-> host_oe_n && $past(host_oe_n))
    else $error("acknowledge while host drives");
  AST_ACK_HOLD: assert property (ack_begin |-> host_oe_n throughout ack_pull)
    else $error("acknowledge pull cut short");
  AST_ACK_AFTER_HI: assert property (ack_begin |-> $past(line))
    else $error("acknowledge without line release");
  AST_OD_LOW: assert property (dev_o == 1'b0)
    else $error("device drives a high level");
  AST_NO_FIGHT: assert property (!dev_oe_n |-> host_oe_n)
    else $error("host and device drive together");
  AST_PULL_LOW: assert property (!dev_oe_n |-> !line)
    else $error("acknowledge not seen low");
  AST_LINE: assert property (line == ((host_oe_n | host_o) & dev_oe_n))
    else $error("wire level wrong");
endmodule

// *** dv/led_boost_ctrl_pin_logic_tb.sv ***
// Bench: host end and device end joined on the control pin
`timescale 1ns/1ps
module led_boost_ctrl_pin_logic_tb;
  import led_link_pkg::*;
  localparam logic [CW-1:0] SHUT = 17'h003e8;
  localparam logic [CW-1:0] SELL = 17'h0012c;
  localparam logic [CW-1:0] ACK = 17'h00064;
  localparam logic [CW-1:0] EOS = 17'h002bc;
  logic clock, reset_n, sw_over, fb_low, cmd_valid, rdy, busy, aok, amiss;
  logic swe, hl, flt, owm, seen_ok, seen_miss;
  logic [1:0] cmd_op;
  logic [7:0] cmd_data, fbt;
  logic [4:0] bright;
  int errors, n_checks, cyc;

  led_link_if lnk ();
  led_dev_end #(.HALF_P(17'h00bb8), .SHUT_P(SHUT), .WIN_P(17'h00a28),
    .SELLOW_P(SELL), .ACK_P(ACK), .EOS_P(EOS)) led_dev_end_inst (
    .CLOCK(clock), .RESET_N(reset_n), .LINK(lnk), .SW_OVER(sw_over),
    .FB_LOW(fb_low), .SWITCH_EN(swe), .HALF_LIMIT(hl), .FAULT(flt),
    .ONEWIRE_MODE(owm), .BRIGHTNESS(bright), .FB_TARGET(fbt));
  led_host_end #(.SHUT_P(SHUT), .SELLOW_P(SELL), .ACK_P(ACK), .EOS_P(EOS))
    led_host_end_inst (.CLOCK(clock), .RESET_N(reset_n), .LINK(lnk),
    .CMD_VALID(cmd_valid), .CMD_READY(rdy), .CMD_OP(cmd_op),
    .CMD_DATA(cmd_data), .BUSY(busy), .ACK_OK(aok), .ACK_MISS(amiss));
  led_link_chk #(.ACK_P(ACK)) led_link_chk_inst (.CLOCK(clock),
    .RESET_N(reset_n), .host_o(lnk.host_o), .host_oe_n(lnk.host_oe_n),
    .dev_o(lnk.dev_o), .dev_oe_n(lnk.dev_oe_n), .line(lnk.line));

  // Clock at 20 MHz
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 100000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One command through the queue, held until taken
  task automatic cmd(input logic [1:0] op, input logic [7:0] d);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    @(negedge clock);
    while (rdy !== 1'b1) @(negedge clock);
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask

  // Wait for the host to finish, noting acknowledge pulses
  task automatic idle();
    seen_ok = 1'b0;
    seen_miss = 1'b0;
    for (int i = 0; i < 3 || busy !== 1'b0; i++) begin
      @(negedge clock);
      seen_ok |= aok;
      seen_miss |= amiss;
    end
  endtask

  task automatic ov(input logic v, input int n);
    @(posedge clock);
    sw_over <= v;
    fb_low <= v;
    repeat (n) @(negedge clock);
  endtask

  // Queue of shutdowns filled until refused, then drained
  task automatic t_fill();
    int acc;
    acc = 0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= OP_OFF;
    @(negedge clock);
    while (rdy === 1'b1 && acc < 20) begin
      acc++;
      @(negedge clock);
    end
    @(posedge clock);
    cmd_valid <= 1'b0;
    chk(8'(acc), 8'h11);
    idle();
    chk(8'(rdy), 8'h01);
    chk(8'(swe), 8'h00);
  endtask

  task automatic t_pwm();
    cmd(OP_PWM, 8'h00);
    idle();
    chk(8'(swe), 8'h01);
    chk(8'(owm), 8'h00);
    chk(8'(hl), 8'h01);
    chk(fbt, 8'h00);
    repeat (2400) @(negedge clock);
    chk(8'(hl), 8'h00);
    chk(8'(owm), 8'h00);
  endtask

  task automatic t_fault();
    ov(1'b1, 198);
    chk(8'(flt), 8'h00);
    ov(1'b0, 40);
    ov(1'b1, 330);
    chk(8'(flt), 8'h01);
    chk(8'(swe), 8'h00);
    ov(1'b0, 100);
    chk(8'(flt), 8'h01);
    cmd(OP_OFF, 8'h00);
    idle();
    cmd(OP_PWM, 8'h00);
    idle();
    chk(8'(flt), 8'h00);
    chk(8'(swe), 8'h01);
  endtask

  task automatic t_frame(input logic [7:0] d, input logic [4:0] b,
                         input logic ok, input logic miss);
    cmd(OP_SEND, d);
    idle();
    chk(8'(seen_ok), 8'(ok));
    chk(8'(seen_miss), 8'(miss));
    chk(8'(bright), 8'(b));
  endtask

  task automatic t_wire();
    cmd(OP_OFF, 8'h00);
    idle();
    chk(8'(swe), 8'h00);
    cmd(OP_ONEWIRE, 8'h00);
    idle();
    chk(8'(owm), 8'h01);
    t_frame(8'h8a, 5'h0a, 1'b1, 1'b0);
    t_frame(8'ha5, 5'h0a, 1'b0, 1'b1);
    t_frame(8'h13, 5'h13, 1'b0, 1'b0);
    cmd(OP_OFF, 8'h00);
    idle();
    cmd(OP_PWM, 8'h00);
    idle();
    chk(8'(owm), 8'h00);
    chk(8'(bright), 8'h13);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk(8'(bright), 8'h1f);
  endtask

  initial begin
    reset_n = 1'b0;
    sw_over = 1'b0;
    fb_low = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_data = 8'h00;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    chk(8'(bright), 8'h1f);
    chk(8'(owm), 8'h00);
    t_fill();
    t_pwm();
    t_fault();
    t_wire();
    print_verdict();
  end
endmodule
